// ==== bench/pdem_energy_manager_chk.sv ====
// Purpose: Port assertions for the energy manager.
// Assumes: Peripheral enables stay steady while a low level is held.
// Notes: Bound to the top after the module.
`timescale 1ns/1ns
module pdem_chk #(
    parameter int SETTLE = 8
) (
    input logic clk_sys,
    input logic rst_b,
    input logic [2:0] lvl_req,
    input logic lvl_req_vld,
    input logic wake_evt,
    input logic [3:0] aux_periph_en,
    input logic supply_low,
    input logic always_on_domain_r,
    input logic base_low_power_domain_r,
    input logic [3:0] aux_domain_r,
    input logic active_domain_r,
    input logic [1:0] vs_target_r,
    input logic [1:0] vs_run_cfg_r,
    input logic [1:0] vs_low_cfg_r,
    input logic [2:0] energy_level_r,
    input logic core_release_r,
    input logic supply_low_flag_r
);
    localparam int REL = 2 * SETTLE + 4;
    wire low_w = energy_level_r == 3'h2 || energy_level_r == 3'h3;
    wire go_w = core_release_r && lvl_req_vld && energy_level_r < 3'h4;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------------
    // Wake sequence pieces
    // ------------------------------------------------------------------
    sequence wake_s;
        low_w && wake_evt && !core_release_r;
    endsequence
    sequence back_s;
        energy_level_r == 3'h0 && active_domain_r && aux_domain_r == 4'hf;
    endsequence
    aon_on_a: assert property (always_on_domain_r)
        else $error("always-on domain dropped");
    shutoff_off_a: assert property (energy_level_r == 3'h4 |->
        !base_low_power_domain_r && aux_domain_r == 4'h0)
        else $error("low-power domain on in shutoff");
    base_on_a: assert property (energy_level_r < 3'h4 |->
        base_low_power_domain_r) else $error("base domain off");
    aux_use_a: assert property (low_w |->
        aux_domain_r == {|$past(aux_periph_en), $past(aux_periph_en[2:0])})
        else $error("aux domain power wrong");
    active_lvl_a: assert property (
        active_domain_r == (energy_level_r < 3'h2))
        else $error("active domain power wrong");
    req_take_a: assert property (go_w && lvl_req < 3'h5 |=>
        energy_level_r == $past(lvl_req)) else $error("request lost");
    low_tgt_a: assert property (go_w && lvl_req[2:1] == 2'h1 |=>
        vs_target_r == $past(vs_low_cfg_r) && !core_release_r)
        else $error("low scaling not applied");
    run_tgt_a: assert property (core_release_r && $past(core_release_r) &&
        energy_level_r < 3'h2 && $stable(vs_run_cfg_r) |->
        vs_target_r == vs_run_cfg_r) else $error("run scaling not applied");
    run_rst_a: assert property ($rose(rst_b) |->
        vs_run_cfg_r == 2'h2 && vs_target_r == 2'h2)
        else $error("run scaling reset wrong");
    wake_seq_a: assert property (wake_s |=> back_s ##1
        (!core_release_r)[*8] ##[1:REL]
        (core_release_r && vs_target_r == vs_run_cfg_r))
        else $error("wake order wrong");
    flag_set_a: assert property (supply_low[*4] |->
        ##[1:2] supply_low_flag_r) else $error("low supply not flagged");
endmodule

bind pdem_energy_manager pdem_chk #(.SETTLE(SETTLE)) pdem_chk_inst (
    .clk_sys, .rst_b, .lvl_req, .lvl_req_vld, .wake_evt, .aux_periph_en,
    .supply_low, .always_on_domain_r, .base_low_power_domain_r,
    .aux_domain_r, .active_domain_r, .vs_target_r, .vs_run_cfg_r,
    .vs_low_cfg_r, .energy_level_r, .core_release_r, .supply_low_flag_r);

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the energy manager.
// Assumes: Enables change only while the core runs.
// Notes: A small model predicts every settled output, release and target outside shutoff only.
`timescale 1ns/1ns
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] lvl_req = 3'h0;
    logic lvl_req_vld = 1'b0;
    logic wake_evt = 1'b0;
    logic [1:0] vs_run_sel = 2'h0;
    logic vs_run_sel_we = 1'b0;
    logic [1:0] vs_low_sel = 2'h0;
    logic vs_low_sel_we = 1'b0;
    logic [3:0] aux_periph_en = 4'h0;
    logic supply_low = 1'b0;
    logic supply_flag_clr = 1'b0;
    wire aon, base, act, rel, flag;
    wire [3:0] aux;
    wire [1:0] tgt, run_cfg, low_cfg;
    wire [2:0] lvl;
    logic [2:0] m_lvl, l;
    logic [1:0] m_run, m_low;
    logic m_rel, m_flag;
    logic [31:0] r;
    int n_fail = 0;
    int n_tests = 0;
    int seed = 96;
    int k;
    always #5 clk_sys = ~clk_sys;
    pdem_energy_manager #(.SETTLE(8)) pdem_energy_manager_inst (
        .clk_sys, .rst_b, .lvl_req, .lvl_req_vld, .wake_evt, .vs_run_sel,
        .vs_run_sel_we, .vs_low_sel, .vs_low_sel_we, .aux_periph_en,
        .supply_low, .supply_flag_clr, .always_on_domain_r(aon),
        .base_low_power_domain_r(base), .aux_domain_r(aux),
        .active_domain_r(act), .vs_target_r(tgt), .vs_run_cfg_r(run_cfg),
        .vs_low_cfg_r(low_cfg), .energy_level_r(lvl),
        .core_release_r(rel), .supply_low_flag_r(flag));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk_all;
        logic [3:0] e;
        e = {|aux_periph_en, aux_periph_en[2:0]};
        if (m_lvl < 3'h2) e = 4'hf;
        if (m_lvl == 3'h4) e = 4'h0;
        chk(4'(lvl), 4'(m_lvl));
        chk(4'(aon), 4'h1);
        chk(4'(base), 4'(m_lvl != 3'h4));
        chk(aux, e);
        chk(4'(act), 4'(m_lvl < 3'h2));
        chk({run_cfg, low_cfg}, {m_run, m_low});
        chk(4'(flag), 4'(m_flag));
        if (m_lvl != 3'h4) begin
            chk(4'(rel), 4'(m_rel));
            chk(4'(tgt), 4'(m_lvl < 3'h2 ? m_run : m_low));
        end
    endtask
    task automatic req(input logic [2:0] q);
        lvl_req = q;
        lvl_req_vld = 1'b1;
        cyc(1);
        lvl_req_vld = 1'b0;
        if (m_rel && q < 3'h5) begin
            m_lvl = q;
            m_rel = q < 3'h2;
        end
        chk_all();
    endtask
    task automatic wr(input logic [1:0] a, input logic [1:0] b);
        vs_run_sel = a;
        vs_low_sel = b;
        vs_run_sel_we = 1'b1;
        vs_low_sel_we = 1'b1;
        cyc(1);
        vs_run_sel_we = 1'b0;
        vs_low_sel_we = 1'b0;
        if (a == 2'h1 || a == 2'h2) m_run = a;
        if (b != 2'h3) m_low = b;
        cyc(1);
        chk_all();
    endtask
    task automatic wake;
        wake_evt = 1'b1;
        cyc(1);
        wake_evt = 1'b0;
        if (!m_rel && m_lvl != 3'h4) begin
            chk({act, rel, tgt}, {2'h2, m_low});
            m_lvl = 3'h0;
            for (k = 1; k < 40 && rel !== 1'b1; k++) cyc(1);
            chk(4'(k >= 8 && k <= 18), 4'h1);
            if (k == 40) final_report();
            m_rel = 1'b1;
        end
        chk_all();
    endtask
    task automatic do_reset;
        rst_b = 1'b0;
        cyc(16);
        rst_b = 1'b1;
        m_lvl = 3'h0;
        m_run = 2'h2;
        m_low = 2'h0;
        m_rel = 1'b1;
        m_flag = 1'b0;
        chk_all();
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        repeat (40) begin
            r = $random(seed);
            aux_periph_en = r[3:0];
            wr(r[5:4], r[7:6]);
            l = r[10:8];
            if (l == 3'h4) l = 3'h3;
            req(l);
            req(r[13:11] == 3'h4 ? 3'h0 : r[13:11]);
            wake();
        end
        supply_low = 1'b1;
        cyc(3);
        supply_low = 1'b0;
        cyc(3);
        chk_all();
        supply_low = 1'b1;
        supply_flag_clr = 1'b1;
        cyc(6);
        supply_flag_clr = 1'b0;
        m_flag = 1'b1;
        supply_low = 1'b0;
        chk_all();
        supply_flag_clr = 1'b1;
        cyc(1);
        supply_flag_clr = 1'b0;
        cyc(1);
        m_flag = 1'b0;
        chk_all();
        aux_periph_en = 4'hf;
        req(3'h4);
        req(3'h0);
        wake();
        do_reset();
        final_report();
    end
endmodule

// ==== rtl/pdem_aux_ctl.v ====
// Purpose: Power request for the auxiliary low-power domains.
// Assumes: Peripheral enables are summarised per domain.
// Notes: Purely combinational, outputs registered by the top.
`timescale 1ns/1ns
`include "pdem_consts.vh"

module pdem_aux_ctl #(
    parameter N = `PDEM_AUX_N
) (
    input wire low_lvl,
    input wire run_lvl,
    input wire [N-1:0] aux_periph_en,
    output wire [N-1:0] aux_on
);

    // ------------------------------------------------------------------
    // Per-domain demand
    // ------------------------------------------------------------------
    wire [N-1:0] demand;
    wire feed_e;
    genvar i;

    // Domain e also serves peripherals of domains b, c and d.
    assign feed_e = |aux_periph_en[`PDEM_AUX_D:`PDEM_AUX_B]; // see (RULE6)

    generate
        for (i = 0; i < N; i = i + 1) begin : g_dom
            if (i == `PDEM_AUX_E) begin : g_e
                assign demand[i] = aux_periph_en[i] | feed_e;
            end else begin : g_o
                assign demand[i] = aux_periph_en[i];
            end
            // Powered while running, on demand in deep sleep and stop.
            assign aux_on[i] = run_lvl | (low_lvl & demand[i]); // see (RULE4)
        end
    endgenerate
    // Without demand in deep sleep and stop the domain is off. see (RULE5)

endmodule

// ==== rtl/pdem_consts.vh ====
// Purpose: Constants for the power domain energy manager.
// Assumes: Included by every design file of the block.
// Notes: Definitions only.
`ifndef PDEM_CONSTS_VH
`define PDEM_CONSTS_VH

// ----------------------------------------------------------------------
// Energy levels
// ----------------------------------------------------------------------
`define PDEM_LVL_W 3
`define PDEM_LVL_ACTIVE 3'h0
`define PDEM_LVL_SLEEP 3'h1
`define PDEM_LVL_DEEP 3'h2
`define PDEM_LVL_STOP 3'h3
`define PDEM_LVL_SHUTOFF 3'h4

// ----------------------------------------------------------------------
// Voltage scaling codes
// ----------------------------------------------------------------------
`define PDEM_VS_W 2
`define PDEM_VS_LOWEST 2'h0
`define PDEM_VS_INTER 2'h1
`define PDEM_VS_HIGHEST 2'h2

// ----------------------------------------------------------------------
// Auxiliary domain indices, b to e
// ----------------------------------------------------------------------
`define PDEM_AUX_N 4
`define PDEM_AUX_B 0
`define PDEM_AUX_C 1
`define PDEM_AUX_D 2
`define PDEM_AUX_E 3

// ----------------------------------------------------------------------
// Sequencer states and timing
// ----------------------------------------------------------------------
`define PDEM_ST_W 3
`define PDEM_ST_RUN 3'h0
`define PDEM_ST_LOW 3'h1
`define PDEM_ST_WAKE_DOM 3'h2
`define PDEM_ST_WAKE_VS 3'h3
`define PDEM_ST_OFF 3'h4
`define PDEM_SETTLE_CYC 8

// Supply monitor filter length in cycles.
`define PDEM_MON_CYC 4

`endif

// ==== rtl/pdem_energy_manager.v ====
// Purpose: Energy manager switching power domains and voltage scaling.
// Assumes: Software requests levels and peripheral enables as plain ports.
// Notes: All domain switching is automatic; there is no per-domain
//        command.
//
// Overview of operation
// (RULE1) The always-on domain is powered in every level, shutoff too.
// (RULE2) All low-power sub-domains go off on entering shutoff.
// (RULE3) The base low-power domain stays on in levels zero to three.
// (RULE4) An auxiliary domain stays on in deep sleep and stop if used.
// (RULE5) An unused auxiliary domain is off in deep sleep and stop.
// (RULE6) Domain e is also on when domain b, c or d is in use.
// (RULE7) The active domain is always on in active and sleep levels.
// (RULE8) The active domain goes off in deep sleep, stop and shutoff.
// (RULE9) Unlisted peripherals sit in the active domain and lose power.
// (RULE10) Two scaling selections exist, run levels and low levels.
// (RULE11) The run-level scaling selection resets to the highest level.
// (RULE12) Software keeps the clock at or below 40 MHz at intermediate.
// (RULE13) The lowest scaling level is only for deep sleep and stop.
// (RULE14) Target scaling follows the new level on every transition; the code holds it during domain wake and in shutoff.
// (RULE15) A low regulator input raises a flag for regulator bypass.
// (RULE16) Domain switching is driven only by level and enables.
// (RULE17) On wake, domain and scaling return before the core is freed.
`timescale 1ns/1ns
`include "pdem_consts.vh"

module pdem_energy_manager #(
    parameter SETTLE = `PDEM_SETTLE_CYC,
    parameter N_AUX = `PDEM_AUX_N
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [2:0] lvl_req,
    input wire lvl_req_vld,
    input wire wake_evt,
    input wire [1:0] vs_run_sel,
    input wire vs_run_sel_we,
    input wire [1:0] vs_low_sel,
    input wire vs_low_sel_we,
    input wire [N_AUX-1:0] aux_periph_en,
    input wire supply_low,
    input wire supply_flag_clr,
    output reg always_on_domain_r,
    output reg base_low_power_domain_r,
    output reg [N_AUX-1:0] aux_domain_r,
    output reg active_domain_r,
    output reg [1:0] vs_target_r,
    output reg [1:0] vs_run_cfg_r,
    output reg [1:0] vs_low_cfg_r,
    output reg [2:0] energy_level_r,
    output reg core_release_r,
    output reg supply_low_flag_r
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [2:0] lvl_nxt;
    reg [3:0] settle_r;
    reg settle_ld;
    wire settle_done;
    wire run_lvl;
    wire low_lvl;
    wire [N_AUX-1:0] aux_on;
    wire mon_flag;

    function is_run;
        input [2:0] l;
        begin
            is_run = (l == `PDEM_LVL_ACTIVE) || (l == `PDEM_LVL_SLEEP);
        end
    endfunction

    function is_low;
        input [2:0] l;
        begin
            is_low = (l == `PDEM_LVL_DEEP) || (l == `PDEM_LVL_STOP);
        end
    endfunction

    assign run_lvl = is_run(lvl_nxt);
    assign low_lvl = is_low(lvl_nxt);
    assign settle_done = (settle_r == 4'h0);

    // ------------------------------------------------------------------
    // Scaling selections
    // ------------------------------------------------------------------
    // The lowest code is refused for the run selection because it does
    // not support the core running. see (RULE13)
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            vs_run_cfg_r <= `PDEM_VS_HIGHEST; // see (RULE11)
            vs_low_cfg_r <= `PDEM_VS_LOWEST;
        end else begin
            // Two independent selections. see (RULE10)
            if (vs_run_sel_we && vs_run_sel != `PDEM_VS_LOWEST &&
                vs_run_sel <= `PDEM_VS_HIGHEST) begin
                vs_run_cfg_r <= vs_run_sel;
            end
            if (vs_low_sel_we && vs_low_sel <= `PDEM_VS_HIGHEST) begin
                vs_low_cfg_r <= vs_low_sel;
            end
        end
    end

    // ------------------------------------------------------------------
    // Level sequencer
    // ------------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        lvl_nxt = energy_level_r;
        settle_ld = 1'b0;
        case (state_r)
            `PDEM_ST_RUN: begin
                if (lvl_req_vld) begin
                    if (lvl_req == `PDEM_LVL_SHUTOFF) begin
                        lvl_nxt = lvl_req;
                        state_nxt = `PDEM_ST_OFF;
                    end else if (is_low(lvl_req)) begin
                        lvl_nxt = lvl_req;
                        state_nxt = `PDEM_ST_LOW;
                    end else if (is_run(lvl_req)) begin
                        lvl_nxt = lvl_req;
                    end
                end
            end
            `PDEM_ST_LOW: begin
                if (wake_evt) begin
                    lvl_nxt = `PDEM_LVL_ACTIVE;
                    settle_ld = 1'b1;
                    state_nxt = `PDEM_ST_WAKE_DOM;
                end
            end
            `PDEM_ST_WAKE_DOM: begin
                if (settle_done) begin
                    settle_ld = 1'b1;
                    state_nxt = `PDEM_ST_WAKE_VS;
                end
            end
            `PDEM_ST_WAKE_VS: begin
                if (settle_done) begin
                    state_nxt = `PDEM_ST_RUN;
                end
            end
            `PDEM_ST_OFF: begin
                state_nxt = `PDEM_ST_OFF;
            end
            default: begin
                state_nxt = `PDEM_ST_RUN;
                lvl_nxt = `PDEM_LVL_ACTIVE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r <= `PDEM_ST_RUN;
            energy_level_r <= `PDEM_LVL_ACTIVE;
            settle_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            energy_level_r <= lvl_nxt;
            if (settle_ld) begin
                settle_r <= SETTLE[3:0] - 4'h1;
            end else if (!settle_done) begin
                settle_r <= settle_r - 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Auxiliary domains and supply monitor
    // ------------------------------------------------------------------
    pdem_aux_ctl #(
        .N(N_AUX)
    ) u_aux (
        .low_lvl(low_lvl),
        .run_lvl(run_lvl),
        .aux_periph_en(aux_periph_en),
        .aux_on(aux_on)
    );

    pdem_supply_mon #(
        .FILT(`PDEM_MON_CYC)
    ) u_mon (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .supply_low(supply_low),
        .clear(supply_flag_clr),
        .flag_r(mon_flag)
    );

    // ------------------------------------------------------------------
    // Domain switches, scaling target and core release
    // ------------------------------------------------------------------
    // Domain switches depend only on level, sequencer and enables. see (RULE16)
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            always_on_domain_r <= 1'b1;
            base_low_power_domain_r <= 1'b1;
            aux_domain_r <= {N_AUX{1'b1}};
            active_domain_r <= 1'b1;
            vs_target_r <= `PDEM_VS_HIGHEST;
            core_release_r <= 1'b1;
            supply_low_flag_r <= 1'b0;
        end else begin
            always_on_domain_r <= 1'b1; // see (RULE1)
            // Off only in shutoff. see (RULE3) see (RULE2)
            base_low_power_domain_r <= (lvl_nxt != `PDEM_LVL_SHUTOFF);
            aux_domain_r <= aux_on; // see (RULE2)
            // Core and unlisted peripherals share this switch.
            // see (RULE7) see (RULE8) see (RULE9)
            active_domain_r <= run_lvl;
            // Scaling target tracks the new level, held during domain wake and in shutoff. see (RULE14)
            if (low_lvl) begin
                vs_target_r <= vs_low_cfg_r;
            end else if (run_lvl && state_nxt != `PDEM_ST_WAKE_DOM) begin
                vs_target_r <= vs_run_cfg_r;
            end
            // Core freed only after domain and scaling settle.
            // see (RULE17)
            core_release_r <= (state_nxt == `PDEM_ST_RUN);
            supply_low_flag_r <= mon_flag; // see (RULE15)
        end
    end

endmodule

// ==== rtl/pdem_supply_mon.v ====
// Purpose: Filtered low-supply flag for regulator bypass.
// Assumes: supply_low comes from an analog comparator, synchronous.
// Notes: Flag is sticky; set wins over clear.
`timescale 1ns/1ns
`include "pdem_consts.vh"

module pdem_supply_mon #(
    parameter FILT = `PDEM_MON_CYC
) (
    input wire clk_sys,
    input wire rst_b,
    input wire supply_low,
    input wire clear,
    output reg flag_r
);

    // ------------------------------------------------------------------
    // Glitch filter and sticky flag
    // ------------------------------------------------------------------
    reg [3:0] cnt_r;
    wire hit;

    assign hit = supply_low && (cnt_r == FILT[3:0] - 4'h1);

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_r <= 4'h0;
            flag_r <= 1'b0;
        end else begin
            if (!supply_low) begin
                cnt_r <= 4'h0;
            end else if (cnt_r != FILT[3:0] - 4'h1) begin
                cnt_r <= cnt_r + 4'h1;
            end
            if (hit) begin
                flag_r <= 1'b1; // see (RULE15)
            end else if (clear) begin
                flag_r <= 1'b0;
            end
        end
    end

endmodule
